// ===== pkg/hrc_pkg.sv
// package of constants and types for the hibernation rtc controller
// Notes on behaviour
// - low battery sets raw flag when sensing
// - cancel option refuses hibernation on low battery
// - four selectable battery trip levels
// - battery configuration reads back as written
// - hibernation request drops regulator enable
// - enabled wake condition raises regulator enable
// - own state survives processor power cycle
// - rtc disable freezes counters, blocks match
// - seconds counter readable, writable, counts seconds
// - sub-second count in 1/32768 second units
// - seconds equal match raises match event
// - only match index zero exists
// - match register reads back last write
// - masked status is raw and enable
package hrc_pkg;
    localparam int CLK_HZ      = 20_000_000;
    localparam int TIMEBASE_HZ = 32_768;
    localparam int SEC_W       = 32;
    localparam int SUBSEC_W    = 15;
    localparam int LB_LEVELS   = 4;

    localparam logic [SUBSEC_W-1:0] SUBSEC_MAX = 15'h7FFF;
    localparam logic [SEC_W-1:0]    SEC_RST    = 32'h0000_0000;
    localparam logic [SEC_W-1:0]    MATCH_RST  = 32'h0000_0000;
    localparam logic [1:0]          MATCH_IDX0 = 2'h0;

    // battery sense modes
    localparam logic [1:0] LOWBATT_SENSE_OFF        = 2'h0;
    localparam logic [1:0] LOWBATT_SENSE_ONLY       = 2'h1;
    localparam logic [1:0] LOWBATT_SENSE_AND_CANCEL = 2'h2;
    // battery trip levels, 1.9 / 2.1 / 2.3 / 2.5 volts
    localparam logic [1:0] LOWBATT_LEVEL_LOWEST  = 2'h0;
    localparam logic [1:0] LOWBATT_LEVEL_SECOND  = 2'h1;
    localparam logic [1:0] LOWBATT_LEVEL_THIRD   = 2'h2;
    localparam logic [1:0] LOWBATT_LEVEL_HIGHEST = 2'h3;

    typedef struct packed {
        logic [1:0] mode;
        logic [1:0] level;
    } hrc_lowbatt_cfg_type;

    typedef struct packed {
        logic lowbatt;
        logic match;
    } hrc_status_type;

    typedef struct packed {
        logic rtc;
        logic pin;
    } hrc_wake_type;

    localparam hrc_lowbatt_cfg_type LOWBATT_CFG_RST = 4'h0;
    localparam hrc_status_type      STATUS_RST      = 2'h0;
    localparam hrc_wake_type        WAKE_RST        = 2'h0;
endpackage : hrc_pkg

// ===== rtl/hrc_tick.sv
// fractional divider giving the 32.768 khz time base enable
`timescale 1ns/100ps
module hrc_tick
    import hrc_pkg::*;
#(
    parameter int CLK_FREQ  = CLK_HZ,
    parameter int TICK_FREQ = TIMEBASE_HZ
) (
    input  wire logic clk_sys_in,  // system clock
    input  wire logic rst_in,      // sync reset, active high
    output logic      tick_out     // one-cycle time base enable
);
    localparam int ACC_W = $clog2(CLK_FREQ) + 1;
    localparam logic [ACC_W-1:0] STEP  = ACC_W'(TICK_FREQ);
    localparam logic [ACC_W-1:0] LIMIT = ACC_W'(CLK_FREQ);

    if (TICK_FREQ <= 0 || 2 * TICK_FREQ > CLK_FREQ) begin : g_bad_rate
        $error("hrc_tick: tick rate must be below half the clock");
    end

    logic [ACC_W-1:0] acc;
    logic [ACC_W-1:0] next_acc;
    logic             next_tick;

    // 20 mhz is no integer multiple, so ticks jitter by one cycle
    always_comb begin
        next_acc  = acc + STEP;
        next_tick = 1'b0;
        if (next_acc >= LIMIT) begin
            next_acc  = next_acc - LIMIT;
            next_tick = 1'b1;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            acc      <= '0;
            tick_out <= 1'b0;
        end else begin
            acc      <= next_acc;
            tick_out <= next_tick;
        end
    end
endmodule : hrc_tick

// ===== rtl/hrc_top.sv
// hibernation controller: rtc, match, battery sense, regulator control
`timescale 1ns/100ps
module hrc_top
    import hrc_pkg::*;
(
    input  wire logic                clk_sys_in,     // system clock
    input  wire logic                rst_in,         // sync reset
    input  wire logic                rtc_en_in,      // rtc enable level
    input  wire logic                sec_wr_in,      // load seconds
    input  wire logic [SEC_W-1:0]    sec_wdata_in,   // seconds value
    input  wire logic                match_wr_in,    // write match
    input  wire logic [1:0]          match_idx_in,   // match index
    input  wire logic [SEC_W-1:0]    match_wdata_in, // match value
    input  wire logic                lb_cfg_wr_in,   // write batt cfg
    input  wire hrc_lowbatt_cfg_type lb_cfg_in,      // batt cfg value
    input  wire logic [LB_LEVELS-1:0] batt_low_cmp_in, // per-level cmp
    input  wire logic                int_en_wr_in,   // write int mask
    input  wire hrc_status_type      int_en_in,      // int mask value
    input  wire hrc_status_type      int_clr_in,     // clear raw flags
    input  wire hrc_wake_type        wake_en_in,     // wake sources
    input  wire logic                wake_pin_in,    // external wake
    input  wire logic                hib_req_in,     // request pulse
    output logic [SEC_W-1:0]         sec_out,        // seconds
    output logic [SUBSEC_W-1:0]      subsec_out,     // sub-seconds
    output logic [SEC_W-1:0]         match_out,      // match readback
    output hrc_lowbatt_cfg_type      lb_cfg_out,     // batt cfg readback
    output hrc_status_type           raw_status_out, // raw flags
    output hrc_status_type           masked_status_out, // masked flags
    output hrc_status_type           int_en_out,     // int mask
    output logic                     regulator_en_out, // ext regulator
    output logic                     cpu_rst_out,    // processor held off
    output logic                     hib_cancel_out  // request refused
);
    typedef enum logic {ST_RUN, ST_HIB} hrc_state_type;

    logic                tick;
    logic [SEC_W-1:0]    sec, next_sec;
    logic [SUBSEC_W-1:0] subsec, next_subsec;
    logic [SEC_W-1:0]    match_val, next_match_val;
    hrc_lowbatt_cfg_type lb_cfg, next_lb_cfg;
    hrc_status_type      raw, next_raw, int_en, next_int_en;
    hrc_state_type       state, next_state;
    logic                cancel, next_cancel;
    logic [LB_LEVELS-1:0] batt_meta, batt_sync;
    logic                pin_q, next_pin_q;
    logic                batt_low_now, match_hit, pin_edge, wake_now;
    logic                abort_now;

    hrc_tick #(
        .CLK_FREQ  (CLK_HZ),
        .TICK_FREQ (TIMEBASE_HZ)
    ) u_tick (
        .clk_sys_in (clk_sys_in),
        .rst_in     (rst_in),
        .tick_out   (tick)
    );

    // comparators settle on the slow battery domain
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            batt_meta <= '0;
            batt_sync <= '0;
        end else begin
            batt_meta <= batt_low_cmp_in;
            batt_sync <= batt_meta;
        end
    end

    always_comb begin
        batt_low_now = (lb_cfg.mode != LOWBATT_SENSE_OFF)
                       && batt_sync[lb_cfg.level];
        abort_now = batt_low_now
                    && (lb_cfg.mode == LOWBATT_SENSE_AND_CANCEL);
        match_hit = rtc_en_in && (sec == match_val);
        pin_edge  = wake_pin_in && !pin_q;
        wake_now  = (wake_en_in.rtc && match_hit)
                    || (wake_en_in.pin && pin_edge);
    end

    // time counters
    always_comb begin
        next_sec    = sec;
        next_subsec = subsec;
        if (!rtc_en_in) begin
            next_sec    = sec;
            next_subsec = subsec;
        end else if (sec_wr_in) begin
            next_sec    = sec_wdata_in;
            next_subsec = '0;
        end else if (tick) begin
            if (subsec == SUBSEC_MAX) begin
                next_subsec = '0;
                next_sec    = sec + SEC_W'(1);
            end else begin
                next_subsec = subsec + SUBSEC_W'(1);
            end
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            sec    <= SEC_RST;
            subsec <= '0;
        end else begin
            sec    <= next_sec;
            subsec <= next_subsec;
        end
    end

    // configuration registers
    always_comb begin
        next_match_val = match_val;
        next_lb_cfg    = lb_cfg;
        next_int_en    = int_en;
        if (match_wr_in && match_idx_in == MATCH_IDX0)
            next_match_val = match_wdata_in;
        if (lb_cfg_wr_in)
            next_lb_cfg = lb_cfg_in;
        if (int_en_wr_in)
            next_int_en = int_en_in;
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            match_val <= MATCH_RST;
            lb_cfg    <= LOWBATT_CFG_RST;
            int_en    <= STATUS_RST;
        end else begin
            match_val <= next_match_val;
            lb_cfg    <= next_lb_cfg;
            int_en    <= next_int_en;
        end
    end

    // raw flags: a set in the clearing cycle wins
    always_comb begin
        next_raw.match   = (raw.match && !int_clr_in.match)
                           || match_hit;
        next_raw.lowbatt = (raw.lowbatt && !int_clr_in.lowbatt)
                           || batt_low_now;
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in)
            raw <= STATUS_RST;
        else
            raw <= next_raw;
    end

    // hibernation sequencing; processor power is not our reset
    always_comb begin
        next_state  = state;
        next_cancel = 1'b0;
        next_pin_q  = wake_pin_in;
        unique case (state)
            ST_RUN: begin
                if (hib_req_in) begin
                    if (abort_now)
                        next_cancel = 1'b1;
                    else
                        next_state = ST_HIB;
                end
            end
            ST_HIB: begin
                if (wake_now)
                    next_state = ST_RUN;
            end
        endcase
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            state  <= ST_RUN;
            cancel <= 1'b0;
            pin_q  <= 1'b0;
        end else begin
            state  <= next_state;
            cancel <= next_cancel;
            pin_q  <= next_pin_q;
        end
    end

    assign sec_out           = sec;
    assign subsec_out        = subsec;
    assign match_out         = (match_idx_in == MATCH_IDX0) ? match_val
                                                            : '0;
    assign lb_cfg_out        = lb_cfg;
    assign raw_status_out    = raw;
    assign int_en_out        = int_en;
    assign masked_status_out = raw & int_en;
    assign regulator_en_out  = (state == ST_RUN);
    assign cpu_rst_out       = (state == ST_HIB);
    assign hib_cancel_out    = cancel;

    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);

    property p_lowbatt_flag;
        batt_low_now |=> raw_status_out.lowbatt;
    endproperty
    a_lowbatt_flag: assert property (p_lowbatt_flag)
        else $error("low battery did not set raw flag");

    property p_abort;
        (state == ST_RUN && hib_req_in && abort_now)
            |=> regulator_en_out && hib_cancel_out;
    endproperty
    a_abort: assert property (p_abort)
        else $error("hibernation not cancelled on low battery");

    property p_cfg_readback;
        lb_cfg_wr_in |=> lb_cfg_out == $past(lb_cfg_in);
    endproperty
    a_cfg_readback: assert property (p_cfg_readback)
        else $error("battery configuration readback wrong");

    property p_hib_enter;
        (state == ST_RUN && hib_req_in && !abort_now)
            |=> !regulator_en_out && cpu_rst_out;
    endproperty
    a_hib_enter: assert property (p_hib_enter)
        else $error("regulator not dropped on request");

    property p_wake;
        (state == ST_HIB && wake_en_in.rtc && match_hit)
            |=> regulator_en_out;
    endproperty
    a_wake: assert property (p_wake)
        else $error("no wake on rtc match");

    property p_retain;
        ($rose(regulator_en_out) && !$past(lb_cfg_wr_in)
            && !$past(match_wr_in) && !$past(int_en_wr_in))
            |-> lb_cfg_out == $past(lb_cfg_out)
                && match_val == $past(match_val)
                && int_en_out == $past(int_en_out);
    endproperty
    a_retain: assert property (p_retain)
        else $error("state lost across wake");

    property p_rtc_off;
        !rtc_en_in |=> sec_out == $past(sec_out)
                       && subsec_out == $past(subsec_out);
    endproperty
    a_rtc_off: assert property (p_rtc_off)
        else $error("counters moved while rtc disabled");

    property p_sec_load;
        (rtc_en_in && sec_wr_in) |=> sec_out == $past(sec_wdata_in);
    endproperty
    a_sec_load: assert property (p_sec_load)
        else $error("seconds load failed");

    property p_wrap;
        (rtc_en_in && !sec_wr_in && tick && subsec_out == SUBSEC_MAX)
            |=> subsec_out == '0 && sec_out == $past(sec_out) + SEC_W'(1);
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("sub-second wrap wrong");

    property p_match_idx;
        (match_wr_in && match_idx_in != MATCH_IDX0)
            |=> match_val == $past(match_val);
    endproperty
    a_match_idx: assert property (p_match_idx)
        else $error("reserved match index changed register");

    property p_masked;
        int_en_wr_in |=> masked_status_out
                         == (raw_status_out & $past(int_en_in));
    endproperty
    a_masked: assert property (p_masked)
        else $error("masked status mismatch");

    c_hib_cycle: cover property (hib_req_in ##1 !regulator_en_out
                                 ##[1:1000] regulator_en_out);
    c_cancel: cover property (hib_cancel_out);
    c_wrap: cover property (tick && subsec_out == SUBSEC_MAX
                            && rtc_en_in);
endmodule : hrc_top

// ===== tb/hrc_supply_model.sv
// supply model: backup battery comparators and external regulator
`timescale 1ns/100ps
module hrc_supply_model
    import hrc_pkg::*;
(
    input  wire logic            regulator_en_in,  // regulator control
    input  wire logic [11:0]     batt_mv_in,       // battery millivolts
    output logic [LB_LEVELS-1:0] batt_low_cmp_out, // below each trip level
    output logic                 core_powered_out  // processor supply
);
    // trip points in millivolts, lowest level first
    localparam logic [11:0] TRIP_MV [LB_LEVELS] =
        '{12'h76C, 12'h834, 12'h8FC, 12'h9C4};
    always_comb begin
        for (int i = 0; i < LB_LEVELS; i++) begin
            batt_low_cmp_out[i] = (batt_mv_in < TRIP_MV[i]);
        end
    end
    // no ramp modelled: worst case for a design expecting a settle delay
    assign core_powered_out = regulator_en_in;
endmodule : hrc_supply_model

// ===== tb/test_hibernate_rtc_lowbat_control.sv
// self-checking bench for the hibernation rtc controller
`timescale 1ns/100ps
module test_hibernate_rtc_lowbat_control;
    import hrc_pkg::*;
    logic                 clk_sys_in = 1'b0;
    logic                 rst_in     = 1'b1;
    logic                 rtc_en     = 1'b0;
    logic                 sec_wr     = 1'b0;
    logic                 match_wr   = 1'b0;
    logic                 lb_wr      = 1'b0;
    logic                 int_en_wr  = 1'b0;
    logic                 wake_pin   = 1'b0;
    logic                 hib_req    = 1'b0;
    logic [1:0]           match_idx  = 2'h0;
    logic [SEC_W-1:0]     wdata      = 32'h0;
    logic [11:0]          batt_mv    = 12'hBB8;
    hrc_status_type       int_clr    = 2'h0;
    hrc_wake_type         wake_en    = 2'h0;
    logic [LB_LEVELS-1:0] cmp;
    logic [SEC_W-1:0]     sec_out, match_out;
    logic [SUBSEC_W-1:0]  subsec_out;
    hrc_lowbatt_cfg_type  lb_cfg_out;
    hrc_status_type       raw_status_out, masked_status_out, int_en_out;
    logic                 regulator_en_out, cpu_rst_out, hib_cancel_out;
    logic                 powered;
    int                   fail_count  = 0;
    int                   comparisons = 0;
    int                   cycles      = 0;
    int                   seed        = 32119;

    hrc_top uut (
        .clk_sys_in        (clk_sys_in),
        .rst_in            (rst_in),
        .rtc_en_in         (rtc_en),
        .sec_wr_in         (sec_wr),
        .sec_wdata_in      (wdata),
        .match_wr_in       (match_wr),
        .match_idx_in      (match_idx),
        .match_wdata_in    (wdata),
        .lb_cfg_wr_in      (lb_wr),
        .lb_cfg_in         (wdata[3:0]),
        .batt_low_cmp_in   (cmp),
        .int_en_wr_in      (int_en_wr),
        .int_en_in         (wdata[1:0]),
        .int_clr_in        (int_clr),
        .wake_en_in        (wake_en),
        .wake_pin_in       (wake_pin),
        .hib_req_in        (hib_req),
        .sec_out           (sec_out),
        .subsec_out        (subsec_out),
        .match_out         (match_out),
        .lb_cfg_out        (lb_cfg_out),
        .raw_status_out    (raw_status_out),
        .masked_status_out (masked_status_out),
        .int_en_out        (int_en_out),
        .regulator_en_out  (regulator_en_out),
        .cpu_rst_out       (cpu_rst_out),
        .hib_cancel_out    (hib_cancel_out)
    );
    hrc_supply_model supply (
        .regulator_en_in  (regulator_en_out),
        .batt_mv_in       (batt_mv),
        .batt_low_cmp_out (cmp),
        .core_powered_out (powered)
    );

    initial begin
        forever #25 clk_sys_in = ~clk_sys_in;
    end

    function automatic logic [11:0] trip_mv(input int lvl);
        return 12'h76C + 12'hC8 * 12'(lvl);
    endfunction : trip_mv

    task automatic test_done;
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : test_done

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic step(input int n);
        repeat (n) @(posedge clk_sys_in);
        #1;
    endtask : step

    // kind 0 seconds, 1 match, 2 battery cfg, 3 interrupt mask
    task automatic wr(input int kind, input logic [31:0] v);
        @(posedge clk_sys_in);
        wdata     <= v;
        sec_wr    <= (kind == 0);
        match_wr  <= (kind == 1);
        lb_wr     <= (kind == 2);
        int_en_wr <= (kind == 3);
        @(posedge clk_sys_in);
        {sec_wr, match_wr, lb_wr, int_en_wr} <= 4'h0;
        #1;
    endtask : wr

    task automatic clr(input hrc_status_type v);
        @(posedge clk_sys_in);
        int_clr <= v;
        @(posedge clk_sys_in);
        int_clr <= 2'h0;
        #1;
    endtask : clr

    task automatic hib;
        @(posedge clk_sys_in);
        hib_req <= 1'b1;
        @(posedge clk_sys_in);
        hib_req <= 1'b0;
        #1;
    endtask : hib

    // wake passes one state register inside, so allow a few cycles
    task automatic wait_reg;
        for (int n = 0; n < 4 && regulator_en_out !== 1'b1; n++) begin
            step(1);
        end
    endtask : wait_reg

    always @(posedge clk_sys_in) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count++;
            $display("[ERR] run length expected end seen hang");
            test_done();
        end
    end

    initial begin
        logic [SEC_W-1:0] v;
        logic [SEC_W-1:0] m;
        logic [SUBSEC_W-1:0] s;
        int               n;
        repeat (16) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        step(1);
        chk("regulator", 1, regulator_en_out);
        chk("sleep", 0, cpu_rst_out);
        wr(0, 32'h0000_1234);
        step(1400);
        chk("frozen sec", 0, sec_out);
        chk("frozen subsec", 0, subsec_out);
        $display("test disabled rtc done");
        @(posedge clk_sys_in);
        rtc_en <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            v = $random(seed);
            m = $random(seed);
            wr(0, v);
            chk("sec load", v, sec_out);
            chk("subsec clear", 0, subsec_out);
            wr(1, m);
            chk("match", m, match_out);
        end
        // first pass only aligns to a tick; second measures a full gap
        for (int k = 0; k < 2; k++) begin
            s = subsec_out;
            for (n = 0; n < 700 && subsec_out === s; n++) begin
                step(1);
            end
            chk("subsec tick", s + 1'b1, subsec_out);
        end
        chk("tick gap", 1, n == 610 || n == 611);
        chk("sec held", v, sec_out);
        @(posedge clk_sys_in);
        match_idx <= 2'h2;
        wr(1, 32'hDEAD_BEEF);
        chk("reserved idx", 0, match_out);
        @(posedge clk_sys_in);
        match_idx <= 2'h0;
        step(1);
        chk("idx zero", m, match_out);
        $display("test counters done");
        wr(3, 32'h1);
        chk("int mask", 2'h1, int_en_out);
        wr(1, 32'h100);
        wr(0, 32'h100);
        step(1);
        chk("raw match", 2'h1, raw_status_out);
        chk("masked", 2'h1, masked_status_out);
        wr(3, 32'h2);
        chk("mask off", 2'h0, masked_status_out);
        wr(1, 32'h200);
        clr(2'h1);
        chk("match cleared", 2'h0, raw_status_out);
        $display("test match done");
        for (int lvl = 0; lvl < LB_LEVELS; lvl++) begin
            // mode code 3 must behave as plain sensing
            v = {28'h0, lvl[0] ? LOWBATT_SENSE_AND_CANCEL
                : (lvl[1] ? 2'h3 : LOWBATT_SENSE_ONLY), lvl[1:0]};
            wr(2, v);
            chk("cfg readback", v, lb_cfg_out);
            @(posedge clk_sys_in);
            batt_mv <= trip_mv(lvl) - 12'h1;
            step(4);
            chk("low flag", 2'h2, raw_status_out);
            chk("low masked", 2'h2, masked_status_out);
            @(posedge clk_sys_in);
            batt_mv <= trip_mv(lvl) + 12'h1;
            step(4);
            clr(2'h2);
            chk("level select", 2'h0, raw_status_out);
        end
        wr(2, {28'h0, LOWBATT_SENSE_OFF, LOWBATT_LEVEL_HIGHEST});
        @(posedge clk_sys_in);
        batt_mv <= 12'h640;
        step(5);
        chk("sense off", 2'h0, raw_status_out);
        $display("test battery done");
        wr(2, {28'h0, LOWBATT_SENSE_AND_CANCEL, LOWBATT_LEVEL_HIGHEST});
        step(3);
        hib();
        chk("cancel", 1, hib_cancel_out);
        chk("kept on", 1, regulator_en_out);
        step(1);
        chk("cancel pulse", 0, hib_cancel_out);
        wr(2, {28'h0, LOWBATT_SENSE_ONLY, LOWBATT_LEVEL_LOWEST});
        @(posedge clk_sys_in);
        batt_mv <= 12'hBB8;
        wake_en <= 2'h1;
        step(4);
        hib();
        chk("reg off", 0, regulator_en_out);
        chk("cpu off", 0, powered);
        chk("cpu reset", 1, cpu_rst_out);
        @(posedge clk_sys_in);
        wake_pin <= 1'b1;
        wait_reg();
        chk("pin wake", 1, regulator_en_out);
        chk("sec kept", 32'h100, sec_out);
        chk("match kept", 32'h200, match_out);
        @(posedge clk_sys_in);
        wake_pin <= 1'b0;
        wake_en  <= 2'h2;
        wr(1, 32'h55);
        hib();
        @(posedge clk_sys_in);
        wake_pin <= 1'b1;
        step(4);
        chk("pin ignored", 0, regulator_en_out);
        wr(0, 32'h55);
        wait_reg();
        chk("rtc wake", 1, regulator_en_out);
        $display("test hibernation done");
        test_done();
    end
endmodule : test_hibernate_rtc_lowbat_control
